// File: design/bdctl_top.sv
// board control register with read-only status register and board drives
`default_nettype none
module bdctl_top (
  input  wire logic        clk,               // 200 mhz clock
  input  wire logic        rst,               // power-on reset, async, high
  // processor local bus
  input  wire logic        reg_block_chip_select_n, // block chip select
  input  wire logic        bus_strobe,        // access strobe, held until ack
  input  wire logic        bus_write,         // 1 write, 0 read
  input  wire logic [3:0]  bus_offset,        // byte offset in block
  input  wire logic [31:0] bus_wdata,         // write data
  output logic [31:0]      bus_rdata,         // read data, registered
  output logic             bus_ack,           // access done pulse
  // auxiliary register side
  input  wire logic        aux_unlock,        // aux wrote 1 to release the enable-bit lock
  // board inputs
  input  wire logic [12:0] board_status_in,   // presence detect and tools id
  input  wire logic        hard_reset,        // processor hard reset active
  input  wire logic        twelve_present,    // 12 v rail available
  // board configuration outputs
  output logic             flash_enable_n,    // flash mapped
  output logic             dram_enable_n,     // dynamic memory mapped
  output logic             lan_transceiver_enable_n, // lan transceiver on
  output logic             infrared_enable_n, // infrared transceiver on
  output logic             flash_cfg_enable_n,// flash gives reset config
  output logic             block_enable_lock_n, // enable-bit lock
  output logic             reg_block_enable_n,  // block mapped
  output logic             serial_line_enable_n,// serial transceiver on
  output logic             card_channel_enable_n, // card buffers on
  output logic             card_supply_on_n,  // card 5 v on
  output logic [1:0]       card_prog_voltage_sel, // card vpp select
  output logic             dram_half_word_n,  // dram 16 bit mode
  output logic             boot_select_offboard, // boot select freed
  output logic             mem_banks_offboard,   // both bank selects freed
  output logic             block_select_offboard,// block select freed
  output logic             hrcfg_drive,       // config register drives bus
  output logic             flash_cfg_drive,   // flash word drives config
  output logic             vpp_zero_on,       // card vpp at 0 v
  output logic             vpp_five_on,       // card vpp at 5 v
  output logic             vpp_twelve_on      // card vpp at 12 v
);

  // ==========================================================================
  // access decode
  bdctl_pkg::bdctl_bus_state_t state_reg;     // responder state
  bdctl_pkg::bdctl_bus_state_t state_next;    // next responder state
  logic take;                                 // access accepted this cycle
  logic ctrl_hit;                             // control register selected
  logic stat_hit;                             // status register selected
  logic ctrl_write;                           // write to control register
  logic [31:0] rdata_next;                    // read word to capture

  // a disabled block does not see its chip select at all
  assign take = bus_strobe & ~reg_block_chip_select_n
              & ~reg_block_enable_n
              & (state_reg == bdctl_pkg::BD_IDLE);
  assign ctrl_hit   = (bus_offset == bdctl_pkg::OFF_MODULE_CTRL);
  assign stat_hit   = (bus_offset == bdctl_pkg::OFF_STATUS_ONE);
  assign ctrl_write = take & bus_write & ctrl_hit;

  // ==========================================================================
  // responder state machine: one answer cycle after each taken access
  always_comb begin
    case (state_reg)
      bdctl_pkg::BD_IDLE: state_next = take ? bdctl_pkg::BD_RESP
                                            : bdctl_pkg::BD_IDLE;
      bdctl_pkg::BD_RESP: state_next = bdctl_pkg::BD_IDLE;
      default:            state_next = bdctl_pkg::BD_IDLE;  // illegal code
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= bdctl_pkg::BD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // handshake output straight from the state
  assign bus_ack = (state_reg == bdctl_pkg::BD_RESP);

  // ==========================================================================
  // configuration bits: loaded only by power-on reset, never by hard reset,
  // so a disabled block keeps steering the board with its last contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_enable_n           <= bdctl_pkg::FLASH_EN_RST;
      dram_enable_n            <= bdctl_pkg::DRAM_EN_RST;
      lan_transceiver_enable_n <= bdctl_pkg::LAN_EN_RST;
      infrared_enable_n        <= bdctl_pkg::IRDA_EN_RST;
      flash_cfg_enable_n       <= bdctl_pkg::FCFG_EN_RST;
      serial_line_enable_n     <= bdctl_pkg::SERIAL_EN_RST;
      card_channel_enable_n    <= bdctl_pkg::CARD_EN_RST;
      card_supply_on_n         <= bdctl_pkg::CARD_VCC_RST;
      card_prog_voltage_sel    <= bdctl_pkg::VPP_SEL_RST;
      dram_half_word_n         <= bdctl_pkg::HALF_WORD_RST;
    end else if (ctrl_write) begin
      // bits 13..31 of the write word are dropped here
      flash_enable_n           <= bus_wdata[bdctl_pkg::FLASH_EN_BIT];
      dram_enable_n            <= bus_wdata[bdctl_pkg::DRAM_EN_BIT];
      lan_transceiver_enable_n <= bus_wdata[bdctl_pkg::LAN_EN_BIT];
      infrared_enable_n        <= bus_wdata[bdctl_pkg::IRDA_EN_BIT];
      flash_cfg_enable_n       <= bus_wdata[bdctl_pkg::FCFG_EN_BIT];
      serial_line_enable_n     <= bus_wdata[bdctl_pkg::SERIAL_EN_BIT];
      card_channel_enable_n    <= bus_wdata[bdctl_pkg::CARD_EN_BIT];
      card_supply_on_n         <= bus_wdata[bdctl_pkg::CARD_VCC_BIT];
      card_prog_voltage_sel    <= bus_wdata[bdctl_pkg::VPP_HI_BIT:
                                            bdctl_pkg::VPP_LO_BIT];
      dram_half_word_n         <= bus_wdata[bdctl_pkg::HALF_WORD_BIT];
    end
  end

  // ==========================================================================
  // block enable: only a write made while unlocked may change it; once high
  // the block is unreachable, so only power-on brings it back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_block_enable_n <= bdctl_pkg::BLOCK_EN_RST;
    end else if (ctrl_write && block_enable_lock_n) begin
      reg_block_enable_n <= bus_wdata[bdctl_pkg::BLOCK_EN_BIT];
    end
  end

  // ==========================================================================
  // enable-bit lock: re-armed by every control write, released by aux unlock;
  // an unlock arriving with a control write wins so it is not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_enable_lock_n <= bdctl_pkg::LOCK_RST;
    end else if (aux_unlock) begin
      block_enable_lock_n <= 1'b1;
    end else if (ctrl_write) begin
      block_enable_lock_n <= 1'b0;
    end
  end

  // ==========================================================================
  // read data: captured at the take, held until the next taken access
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus_write) begin
      rdata_next = 32'h0000_0000;                            // writes return zero
    end else if (ctrl_hit) begin
      rdata_next[bdctl_pkg::FLASH_EN_BIT]  = flash_enable_n;
      rdata_next[bdctl_pkg::DRAM_EN_BIT]   = dram_enable_n;
      rdata_next[bdctl_pkg::LAN_EN_BIT]    = lan_transceiver_enable_n;
      rdata_next[bdctl_pkg::IRDA_EN_BIT]   = infrared_enable_n;
      rdata_next[bdctl_pkg::FCFG_EN_BIT]   = flash_cfg_enable_n;
      rdata_next[bdctl_pkg::LOCK_BIT]      = block_enable_lock_n;
      rdata_next[bdctl_pkg::BLOCK_EN_BIT]  = reg_block_enable_n;
      rdata_next[bdctl_pkg::SERIAL_EN_BIT] = serial_line_enable_n;
      rdata_next[bdctl_pkg::CARD_EN_BIT]   = card_channel_enable_n;
      rdata_next[bdctl_pkg::CARD_VCC_BIT]  = card_supply_on_n;
      rdata_next[bdctl_pkg::VPP_HI_BIT:bdctl_pkg::VPP_LO_BIT] = card_prog_voltage_sel;
      rdata_next[bdctl_pkg::HALF_WORD_BIT] = dram_half_word_n;
    end else if (stat_hit) begin
      rdata_next[bdctl_pkg::STAT_WIDTH-1:0] = board_status_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (take) begin
      bus_rdata <= rdata_next;
    end
  end

  // ==========================================================================
  // chip-select release and hard-reset config source
  assign boot_select_offboard  = flash_enable_n;
  assign mem_banks_offboard    = dram_enable_n;
  assign block_select_offboard = reg_block_enable_n;
  // only one source may drive the data bus during hard reset
  assign hrcfg_drive     = hard_reset & flash_cfg_enable_n;
  assign flash_cfg_drive = hard_reset & ~flash_cfg_enable_n;

  // ==========================================================================
  // card programming voltage switches
  bdctl_vpp_dec u_vpp_dec (
    .clk            (clk),
    .vpp_sel        (card_prog_voltage_sel),
    .twelve_present (twelve_present),
    .vpp_zero_on    (vpp_zero_on),
    .vpp_five_on    (vpp_five_on),
    .vpp_twelve_on  (vpp_twelve_on)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence read_taken(logic [3:0] off);
    bus_strobe && !reg_block_chip_select_n && !reg_block_enable_n
      && state_reg == bdctl_pkg::BD_IDLE && !bus_write && bus_offset == off;
  endsequence

  sequence write_taken;
    bus_strobe && !reg_block_chip_select_n && !reg_block_enable_n
      && state_reg == bdctl_pkg::BD_IDLE && bus_write
      && bus_offset == bdctl_pkg::OFF_MODULE_CTRL;
  endsequence

  lock_rearm_a: assert property (write_taken ##0 !aux_unlock |=>
    !block_enable_lock_n)
    else $error("lock not re-armed after control write");

  // the answer is a single-cycle pulse; a strobe still held once the responder is back in idle is taken again
  ack_pulse_a: assert property (bus_ack |=> !bus_ack)
    else $error("answer pulse stood too long");

  // writes elsewhere in the window must leave the board setup alone
  stray_write_a: assert property (bus_strobe && !reg_block_chip_select_n && bus_write
    && bus_offset != bdctl_pkg::OFF_MODULE_CTRL |=> $stable(card_prog_voltage_sel)
    && $stable(flash_enable_n) && $stable(dram_half_word_n))
    else $error("stray write changed control bits");

  locked_enable_a: assert property (write_taken ##0 !block_enable_lock_n |=>
    $stable(reg_block_enable_n))
    else $error("enable bit changed while locked");

  enable_rise_a: assert property ($rose(reg_block_enable_n) |->
    $past(block_enable_lock_n))
    else $error("block disabled without unlock");

  unlock_set_a: assert property (aux_unlock |=> block_enable_lock_n)
    else $error("aux unlock did not release lock");

  lock_hold_a: assert property (!aux_unlock && !block_enable_lock_n |=>
    !block_enable_lock_n)
    else $error("lock released without aux unlock");

  disabled_silent_a: assert property (reg_block_enable_n |=>
    !bus_ack ##1 !bus_ack)
    else $error("disabled block answered");

  ctrl_read_a: assert property (read_taken(bdctl_pkg::OFF_MODULE_CTRL) |=>
    bus_ack && bus_rdata[bdctl_pkg::LOCK_BIT] == $past(block_enable_lock_n)
    && bus_rdata[bdctl_pkg::FLASH_EN_BIT] == $past(flash_enable_n))
    else $error("control readback wrong");

  status_read_a: assert property (read_taken(bdctl_pkg::OFF_STATUS_ONE) |=>
    bus_ack && bus_rdata[12:0] == $past(board_status_in))
    else $error("status readback wrong");

  reserved_zero_a: assert property (bus_ack |-> bus_rdata[31:13] == 19'h0)
    else $error("reserved bits read nonzero");

  ctrl_write_a: assert property (write_taken |=>
    flash_enable_n == $past(bus_wdata[0]) && dram_half_word_n == $past(bus_wdata[12])
    && card_prog_voltage_sel == $past(bus_wdata[11:10]))
    else $error("control write not stored");

  cfg_hold_a: assert property (hard_reset && !bus_strobe |=>
    $stable(flash_cfg_enable_n) && $stable(lan_transceiver_enable_n))
    else $error("config moved during hard reset");

  cfg_source_a: assert property (hard_reset |-> hrcfg_drive != flash_cfg_drive
    && flash_cfg_drive == !flash_cfg_enable_n)
    else $error("hard reset config source wrong");

endmodule : bdctl_top
`default_nettype wire

// File: inc/bdctl_pkg.sv
// constants shared by the board control register block
`default_nettype none
package bdctl_pkg;
  // ==========================================================================
  // register offsets inside the block window (byte offsets)
  localparam logic [3:0] OFF_MODULE_CTRL = 4'h4;  // board_module_control
  localparam logic [3:0] OFF_STATUS_ONE  = 4'h8;  // board_status_one

  // ==========================================================================
  // board_module_control field positions
  localparam int FLASH_EN_BIT  = 0;   // flash mapped, active low
  localparam int DRAM_EN_BIT   = 1;   // dynamic memory mapped, active low
  localparam int LAN_EN_BIT    = 2;   // lan transceiver enable, active low
  localparam int IRDA_EN_BIT   = 3;   // infrared enable, active low
  localparam int FCFG_EN_BIT   = 4;   // flash supplies reset config, active low
  localparam int LOCK_BIT      = 5;   // enable-bit lock, read only
  localparam int BLOCK_EN_BIT  = 6;   // register block mapped, active low
  localparam int SERIAL_EN_BIT = 7;   // serial line transceiver, active low
  localparam int CARD_EN_BIT   = 8;   // card channel buffers, active low
  localparam int CARD_VCC_BIT  = 9;   // card supply on, active low
  localparam int VPP_LO_BIT    = 10;  // programming voltage select, low bit
  localparam int VPP_HI_BIT    = 11;  // programming voltage select, high bit
  localparam int HALF_WORD_BIT = 12;  // dram 16 bit mode, active low
  localparam int CTRL_WIDTH    = 13;  // implemented bits 0..12
  localparam int STAT_WIDTH    = 13;  // status bits 0..12

  // ==========================================================================
  // power-on defaults
  localparam logic       FLASH_EN_RST  = 1'h0;
  localparam logic       DRAM_EN_RST   = 1'h0;
  localparam logic       LAN_EN_RST    = 1'h1;
  localparam logic       IRDA_EN_RST   = 1'h1;
  localparam logic       FCFG_EN_RST   = 1'h1;
  localparam logic       LOCK_RST      = 1'h0;
  localparam logic       BLOCK_EN_RST  = 1'h0;
  localparam logic       SERIAL_EN_RST = 1'h1;
  localparam logic       CARD_EN_RST   = 1'h1;
  localparam logic       CARD_VCC_RST  = 1'h1;
  localparam logic [1:0] VPP_SEL_RST   = 2'h3;
  localparam logic       HALF_WORD_RST = 1'h1;

  // ==========================================================================
  // programming voltage encodings
  localparam logic [1:0] VPP_ZERO   = 2'h0;  // 0 V
  localparam logic [1:0] VPP_FIVE   = 2'h1;  // 5 V
  localparam logic [1:0] VPP_TWELVE = 2'h2;  // 12 V if that rail exists
  localparam logic [1:0] VPP_HIZ    = 2'h3;  // released

  // bus responder states, one-hot
  typedef enum logic [1:0] {
    BD_IDLE = 2'h1,
    BD_RESP = 2'h2
  } bdctl_bus_state_t;
endpackage : bdctl_pkg
`default_nettype wire

// File: design/bdctl_vpp_dec.sv
// card programming-voltage select decoder
`default_nettype none
module bdctl_vpp_dec (
  input  wire logic       clk,              // clock for the rail check only
  input  wire logic [1:0] vpp_sel,          // card_prog_voltage_sel field
  input  wire logic       twelve_present,   // 12 v rail available
  output logic            vpp_zero_on,      // tie card vpp to 0 v
  output logic            vpp_five_on,      // drive card vpp from 5 v
  output logic            vpp_twelve_on     // drive card vpp from 12 v
);
  // ==========================================================================
  // one rail switch at most; hi-z means all switches open
  always_comb begin
    vpp_zero_on   = 1'b0;
    vpp_five_on   = 1'b0;
    vpp_twelve_on = 1'b0;
    case (vpp_sel)
      bdctl_pkg::VPP_ZERO:   vpp_zero_on = 1'b1;
      bdctl_pkg::VPP_FIVE:   vpp_five_on = 1'b1;
      // without the rail the switch stays open rather than float a dead supply
      bdctl_pkg::VPP_TWELVE: vpp_twelve_on = twelve_present;
      default: begin
        vpp_zero_on = 1'b0;
      end
    endcase
  end

  // never two rails at once
  rail_exclusive_a: assert property (
    @(posedge clk) $onehot0({vpp_zero_on, vpp_five_on, vpp_twelve_on}))
    else $error("two card vpp rails on together");
endmodule : bdctl_vpp_dec
`default_nettype wire

// File: dv/bdctl_cpu_model.sv
// processor-side model of the local bus that reaches the board control block
`default_nettype none
module bdctl_cpu_model (
  input  wire logic        clk,     // bus clock
  input  wire logic [31:0] rdata,   // read data from the block
  input  wire logic        ack,     // access done pulse
  output logic             sel_n,   // block chip select, active low
  output logic             strobe,  // access request
  output logic             wr,      // 1 write, 0 read
  output logic [3:0]       offset,  // byte offset in the block
  output logic [31:0]      wdata    // write data
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // idle bus at time zero
  initial begin
    sel_n  = 1'b1;
    strobe = 1'b0;
    wr     = 1'b0;
    offset = 4'h0;
    wdata  = 32'h0;
  end

  // one access: request held until ack is sampled, bounded wait
  task automatic access(input logic w, input logic [3:0] off, input logic [31:0] d,
                        output logic [31:0] q, output logic got);
    int n;
    got = 1'b0;
    q   = 32'h0;
    @(posedge clk);
    sel_n  <= 1'b0;
    strobe <= 1'b1;
    wr     <= w;
    offset <= off;
    wdata  <= d;
    for (n = 0; n < 6 && !got; n++) begin
      @(posedge clk);
      if (ack === 1'b1) begin  // answer taken at the ack edge
        got = 1'b1;
        q   = rdata;
      end
    end
    // released lines show the inverse, so a stale value cannot pass
    sel_n  <= 1'b1;
    strobe <= 1'b0;
    wr     <= ~w;
    offset <= ~off;
    wdata  <= ~d;
  endtask : access
endmodule : bdctl_cpu_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the board control register block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // signals
  logic        clk, rst, aux_unlock, hard_reset, twelve_present;  // clock, reset, board
  logic        reg_block_chip_select_n, bus_strobe, bus_write, bus_ack;  // bus control
  logic [3:0]  bus_offset;                  // byte offset
  logic [31:0] bus_wdata, bus_rdata;        // bus data
  logic [12:0] board_status_in;             // status pins
  logic        flash_enable_n, dram_enable_n, lan_transceiver_enable_n, infrared_enable_n;
  logic        flash_cfg_enable_n, block_enable_lock_n, reg_block_enable_n;
  logic        serial_line_enable_n, card_channel_enable_n, card_supply_on_n;
  logic        dram_half_word_n, boot_select_offboard, mem_banks_offboard;
  logic        block_select_offboard, hrcfg_drive, flash_cfg_drive;
  logic        vpp_zero_on, vpp_five_on, vpp_twelve_on;  // vpp decode
  logic [1:0]  card_prog_voltage_sel;       // vpp select
  logic [12:0] exp_cfg;                     // expected control bits
  logic [31:0] q;                           // read data from model
  logic        got;                         // access was acked
  int          n_mismatch, check_count;     // counters
  // control bits as seen at the pins, bit n is register bit n
  wire  [12:0] cfg = {dram_half_word_n, card_prog_voltage_sel, card_supply_on_n,
                      card_channel_enable_n, serial_line_enable_n, reg_block_enable_n,
                      block_enable_lock_n, flash_cfg_enable_n, infrared_enable_n,
                      lan_transceiver_enable_n, dram_enable_n, flash_enable_n};
  wire  [7:0]  drv = {boot_select_offboard, mem_banks_offboard, block_select_offboard,
                      hrcfg_drive, flash_cfg_drive, vpp_zero_on, vpp_five_on, vpp_twelve_on};
  // field patterns covering every vpp code; all-ones also tries bit 6 while locked
  localparam logic [31:0] PATS [4] = '{32'hFFFF_FFFF, 32'h0, 32'h0000_0555, 32'hFFFF_FAAA};
  localparam logic [12:0] CFG_DEF  = 13'h1F9C;  // power-on defaults

  bdctl_top u_dut (.clk(clk), .rst(rst), .reg_block_chip_select_n(reg_block_chip_select_n),
    .bus_strobe(bus_strobe), .bus_write(bus_write), .bus_offset(bus_offset),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .aux_unlock(aux_unlock),
    .board_status_in(board_status_in), .hard_reset(hard_reset), .twelve_present(twelve_present),
    .flash_enable_n(flash_enable_n), .dram_enable_n(dram_enable_n),
    .lan_transceiver_enable_n(lan_transceiver_enable_n), .infrared_enable_n(infrared_enable_n),
    .flash_cfg_enable_n(flash_cfg_enable_n), .block_enable_lock_n(block_enable_lock_n),
    .reg_block_enable_n(reg_block_enable_n), .serial_line_enable_n(serial_line_enable_n),
    .card_channel_enable_n(card_channel_enable_n), .card_supply_on_n(card_supply_on_n),
    .card_prog_voltage_sel(card_prog_voltage_sel), .dram_half_word_n(dram_half_word_n),
    .boot_select_offboard(boot_select_offboard), .mem_banks_offboard(mem_banks_offboard),
    .block_select_offboard(block_select_offboard), .hrcfg_drive(hrcfg_drive),
    .flash_cfg_drive(flash_cfg_drive), .vpp_zero_on(vpp_zero_on), .vpp_five_on(vpp_five_on),
    .vpp_twelve_on(vpp_twelve_on));
  bdctl_cpu_model u_cpu (.clk(clk), .rdata(bus_rdata), .ack(bus_ack),
    .sel_n(reg_block_chip_select_n), .strobe(bus_strobe), .wr(bus_write),
    .offset(bus_offset), .wdata(bus_wdata));

  // ==========================================================================
  // clock and watchdog
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  initial begin
    #25000;
    n_mismatch++;  // hang counts as a mismatch
    conclude();
  end

  // ==========================================================================
  // compare and access helpers
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check_word
  task automatic check_flag(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t flag got %h exp %h", $time, g, e);
    end
  endtask : check_flag
  // derived board drives from the expected bits
  function automatic logic [7:0] exp_drv();
    return {exp_cfg[0], exp_cfg[1], exp_cfg[6], hard_reset & exp_cfg[4],
            hard_reset & ~exp_cfg[4], exp_cfg[11:10] == 2'h0, exp_cfg[11:10] == 2'h1,
            exp_cfg[11:10] == 2'h2 && twelve_present};
  endfunction : exp_drv
  task automatic pins();
    check_word({19'h0, cfg}, {19'h0, exp_cfg});
    check_word({24'h0, drv}, {24'h0, exp_drv()});
  endtask : pins
  // control write; bit 6 follows only while unlocked, lock re-arms
  task automatic wr_ctrl(input logic [31:0] d);
    u_cpu.access(1'b1, bdctl_pkg::OFF_MODULE_CTRL, d, q, got);
    exp_cfg = {d[12:7], exp_cfg[5] ? d[6] : exp_cfg[6], 1'b0, d[4:0]};
    check_flag(got, 1'b1);
    pins();
  endtask : wr_ctrl
  task automatic rd_chk(input logic [3:0] off, input logic [31:0] e, input logic en);
    u_cpu.access(1'b0, off, 32'h0, q, got);
    check_flag(got, en);
    if (en) check_word(q, e);
  endtask : rd_chk
  task automatic unlock();
    @(posedge clk);
    aux_unlock <= 1'b1;
    @(posedge clk);
    aux_unlock <= 1'b0;
    exp_cfg[5] = 1'b1;
    @(posedge clk);
    pins();
  endtask : unlock

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    aux_unlock = 1'b0;
    hard_reset = 1'b0;
    twelve_present = 1'b0;
    board_status_in = 13'h1A5B;
    n_mismatch = 0;
    check_count = 0;
    exp_cfg = CFG_DEF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pins();
    rd_chk(4'h4, {19'h0, CFG_DEF}, 1'b1);
    rd_chk(4'h8, 32'h0000_1A5B, 1'b1);
    u_cpu.access(1'b1, 4'h8, 32'h0, q, got);
    pins();
    for (int i = 0; i < 2; i++) begin
      rd_chk(i ? 4'hC : 4'h0, 32'h0, 1'b1);
      u_cpu.access(1'b1, i ? 4'hC : 4'h0, 32'h0, q, got);
      pins();
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      twelve_present <= (i >= 4);
      hard_reset <= i[0] ^ i[2];
      wr_ctrl(PATS[i % 4]);
      rd_chk(4'h4, {19'h0, exp_cfg}, 1'b1);
    end
    unlock();
    wr_ctrl(32'h0000_0000);
    wr_ctrl(32'h0000_0040);
    unlock();
    wr_ctrl(32'h0000_1F40);
    rd_chk(4'h4, 32'h0, 1'b0);
    u_cpu.access(1'b1, 4'h4, 32'h0, q, got);
    check_flag(got, 1'b0);
    @(posedge clk);
    hard_reset <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    pins();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    exp_cfg = CFG_DEF;
    @(posedge clk);
    pins();
    rd_chk(4'h4, {19'h0, CFG_DEF}, 1'b1);
    conclude();
  end

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
endmodule : testbench
`default_nettype wire
